// ### hdl/src_pkg.sv
// src_pkg: constants shared by the system reset controller.
// assumes a single 40 MHz core clock domain.
`default_nettype none
package src_pkg;
  // ---------------------------------------------------------------
  // reset source indices
  // ---------------------------------------------------------------
  localparam int unsigned NUM_SRC = 8;
  localparam int unsigned SRC_POR = 0;
  localparam int unsigned SRC_PIN = 1;
  localparam int unsigned SRC_CMP = 2;
  localparam int unsigned SRC_SW = 3;
  localparam int unsigned SRC_VMON = 4;
  localparam int unsigned SRC_WDT = 5;
  localparam int unsigned SRC_MCD = 6;
  localparam int unsigned SRC_FLASH = 7;
  localparam logic [7:0] SRC_NONE = 8'h00;
  // ---------------------------------------------------------------
  // reset and exit values
  // ---------------------------------------------------------------
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam int unsigned PORT_W = 8;
  localparam logic [PORT_W-1:0] PORT_LATCH_RST = 8'hff;
  localparam logic [1:0] CLK_SEL_INT = 2'h0;
  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_ST_RESET = 2'b01,
    SRC_ST_RUN = 2'b10
  } src_state_t;
endpackage
`default_nettype wire

// ### hdl/src_top.sv
// src_top: system reset controller, gathers reset sources and holds
// the rest of the chip in its default state until all are gone.
// assumes all request inputs are synchronous to core_clk.
`default_nettype none
module src_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic por_req,
  input wire logic external_reset_pin_n_i,
  input wire logic cmp_req,
  input wire logic sw_req,
  input wire logic vmon_req,
  input wire logic wdt_req,
  input wire logic mcd_req,
  input wire logic flash_req,
  output logic external_reset_pin_n_o,
  output logic external_reset_pin_n_oe,
  output logic core_halt,
  output logic reg_default_load,
  output logic por_bits_load,
  output logic irq_timer_disable,
  output logic ram_reset,
  output logic [7:0] port_latch_force,
  output logic port_open_drain,
  output logic weak_pullup_en,
  output logic [15:0] pc_load_value,
  output logic pc_load,
  output logic [1:0] sysclk_sel,
  output logic wdt_enable_set,
  output logic [7:0] reset_cause
);
  // ---------------------------------------------------------------
  // request gathering
  // ---------------------------------------------------------------
  logic [7:0] req;
  logic any_req;
  logic drive_pin;
  src_pkg::src_state_t state_q, state_d;
  logic drive_q, drive_d;
  logic por_q, por_d;
  logic exit_q, exit_d;
  logic [7:0] cause_q, cause_d;
  logic in_reset;
  logic leave_now;
  logic enter_now;

  always_comb begin
    req = src_pkg::SRC_NONE;
    req[src_pkg::SRC_POR] = por_req;
    // own pin drive must not look like an external request
    req[src_pkg::SRC_PIN] = ~external_reset_pin_n_i & ~drive_q;
    req[src_pkg::SRC_CMP] = cmp_req;
    req[src_pkg::SRC_SW] = sw_req;
    req[src_pkg::SRC_VMON] = vmon_req;
    req[src_pkg::SRC_WDT] = wdt_req;
    req[src_pkg::SRC_MCD] = mcd_req;
    req[src_pkg::SRC_FLASH] = flash_req;
  end

  assign any_req = |req;
  assign drive_pin = req[src_pkg::SRC_POR] | req[src_pkg::SRC_VMON];

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  assign in_reset = (state_q == src_pkg::SRC_ST_RESET);
  // leave only once all requests are gone
  assign leave_now = in_reset & ~any_req;
  assign enter_now = ~in_reset & any_req;

  always_comb begin
    state_d = state_q;
    case (state_q)
      src_pkg::SRC_ST_RESET: begin
        if (!any_req) begin
          state_d = src_pkg::SRC_ST_RUN;
        end
      end
      src_pkg::SRC_ST_RUN: begin
        if (any_req) begin
          state_d = src_pkg::SRC_ST_RESET;
        end
      end
      default: begin
        // an upset code falls back to the safe side
        state_d = src_pkg::SRC_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= src_pkg::SRC_ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // reset pin drive
  // ---------------------------------------------------------------
  // sticky for the episode so a short por still holds the pin low
  always_comb begin
    drive_d = drive_q;
    if (leave_now) begin
      drive_d = 1'b0;
    end else if (in_reset) begin
      drive_d = drive_q | drive_pin;
    end else if (enter_now) begin
      drive_d = drive_pin;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= drive_d;
    end
  end

  // ---------------------------------------------------------------
  // power-on episode marker
  // ---------------------------------------------------------------
  always_comb begin
    por_d = por_q;
    if (leave_now) begin
      por_d = 1'b0;
    end else if (in_reset) begin
      por_d = por_q | req[src_pkg::SRC_POR];
    end else if (enter_now) begin
      por_d = req[src_pkg::SRC_POR];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      por_q <= 1'b0;
    end else begin
      por_q <= por_d;
    end
  end

  // ---------------------------------------------------------------
  // exit pulse
  // ---------------------------------------------------------------
  // one cycle wide so the core loads its vector only once
  always_comb begin
    exit_d = leave_now;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      exit_q <= 1'b0;
    end else begin
      exit_q <= exit_d;
    end
  end

  // ---------------------------------------------------------------
  // reset cause
  // ---------------------------------------------------------------
  // fresh mask per episode, then every later source is or-ed in
  always_comb begin
    cause_d = cause_q;
    if (enter_now) begin
      cause_d = req;
    end else if (in_reset & any_req) begin
      cause_d = cause_q | req;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cause_q <= src_pkg::SRC_NONE;
    end else begin
      cause_q <= cause_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs to the rest of the chip
  // ---------------------------------------------------------------
  assign core_halt = in_reset;
  assign reg_default_load = in_reset;
  // por-only bits keep their value on other resets
  assign por_bits_load = in_reset & por_q;
  assign irq_timer_disable = in_reset;
  // ram has no reset path at all
  assign ram_reset = 1'b0;
  assign port_latch_force = in_reset ? src_pkg::PORT_LATCH_RST
                                     : src_pkg::SRC_NONE;
  assign port_open_drain = in_reset;
  assign weak_pullup_en = 1'b1;
  // pin is open-drain: only ever pulled low
  assign external_reset_pin_n_o = 1'b0;
  assign external_reset_pin_n_oe = drive_q;
  assign pc_load = exit_q;
  assign pc_load_value = src_pkg::RESET_VECTOR;
  assign sysclk_sel = src_pkg::CLK_SEL_INT;
  assign wdt_enable_set = exit_q;
  assign reset_cause = cause_q;
endmodule
`default_nettype wire

// ### bench/src_checker.sv
// checker for src_top, bound to its ports below
// assumes one clock, rst synchronous active high
`default_nettype none
module src_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic por_req,
  input wire logic external_reset_pin_n_i,
  input wire logic cmp_req,
  input wire logic sw_req,
  input wire logic vmon_req,
  input wire logic wdt_req,
  input wire logic mcd_req,
  input wire logic flash_req,
  input wire logic external_reset_pin_n_o,
  input wire logic external_reset_pin_n_oe,
  input wire logic core_halt,
  input wire logic reg_default_load,
  input wire logic por_bits_load,
  input wire logic pc_load,
  input wire logic irq_timer_disable,
  input wire logic ram_reset,
  input wire logic port_open_drain,
  input wire logic weak_pullup_en,
  input wire logic wdt_enable_set,
  input wire logic [7:0] port_latch_force,
  input wire logic [7:0] reset_cause,
  input wire logic [15:0] pc_load_value,
  input wire logic [1:0] sysclk_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] s;
  // pin only counts while we are not pulling it ourselves
  assign s = {flash_req, mcd_req, wdt_req, vmon_req, sw_req, cmp_req,
    ~external_reset_pin_n_i & ~external_reset_pin_n_oe, por_req};
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  halt_entry_a: assert property (|s |=> core_halt)
    else $error("no halt");
  exit_pulse_a: assert property (core_halt && !(|s) |=>
    !core_halt && pc_load && wdt_enable_set) else $error("bad exit");
  cause_first_a: assert property (!core_halt && |s |=>
    reset_cause == $past(s)) else $error("bad cause");
  state_mirror_a: assert property (
    port_latch_force == {8{core_halt}} &&
    irq_timer_disable == core_halt && reg_default_load == core_halt &&
    port_open_drain == core_halt) else $error("bad state outputs");
  fixed_out_a: assert property (
    !ram_reset && weak_pullup_en &&
    !external_reset_pin_n_o && pc_load_value == 16'h0000 &&
    sysclk_sel == 2'h0) else $error("bad fixed outputs");
  pin_drive_a: assert property (por_req || vmon_req |=>
    external_reset_pin_n_oe) else $error("pin not driven");
  pin_release_a: assert property (!core_halt |->
    !external_reset_pin_n_oe && !por_bits_load) else $error("held in run");
  por_bits_a: assert property (por_req |=> por_bits_load)
    else $error("por bits");
  cover property (pc_load);
  cover property (external_reset_pin_n_oe);
  cover property (core_halt && |s ##1 core_halt);
endmodule
bind src_top src_checker src_checker_inst (.*);
`default_nettype wire

// ### bench/src_req_model.sv
// reset requesters and the reset pin with its pull-up
// assumes req is driven by the bench off the clock edge
`default_nettype none
module src_req_model (
  input wire logic [7:0] req,
  input wire logic oe,
  output logic [7:0] lines
);
  timeunit 1ns;
  timeprecision 1ps;
  // bit 1 is the pin level: pulled up, low while anyone pulls it
  assign lines = {req[7:2], ~(req[1] | oe), req[0]};
endmodule
`default_nettype wire

// ### bench/src_top_tb_top.sv
// self-checking bench for src_top
// assumes src_req_model and src_checker are compiled first
`default_nettype none
module src_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst = 1;
  logic [7:0] req = 8'h00, lines, port_latch_force, reset_cause;
  logic external_reset_pin_n_o, external_reset_pin_n_oe, core_halt;
  logic reg_default_load, por_bits_load, irq_timer_disable, ram_reset;
  logic port_open_drain, weak_pullup_en, pc_load, wdt_enable_set;
  logic [15:0] pc_load_value;
  logic [1:0] sysclk_sel;
  int n_errors = 0, checks_done = 0;
  always #12.5 core_clk = ~core_clk;
  src_req_model src_req_model_inst (.req(req),
    .oe(external_reset_pin_n_oe), .lines(lines));
  src_top src_top_inst (.core_clk(core_clk), .rst(rst),
    .por_req(lines[0]),
    .external_reset_pin_n_i(lines[1]), .cmp_req(lines[2]),
    .sw_req(lines[3]), .vmon_req(lines[4]), .wdt_req(lines[5]),
    .mcd_req(lines[6]), .flash_req(lines[7]),
    .external_reset_pin_n_o(external_reset_pin_n_o),
    .external_reset_pin_n_oe(external_reset_pin_n_oe),
    .core_halt(core_halt), .reg_default_load(reg_default_load),
    .por_bits_load(por_bits_load),
    .irq_timer_disable(irq_timer_disable), .ram_reset(ram_reset),
    .port_latch_force(port_latch_force),
    .port_open_drain(port_open_drain), .weak_pullup_en(weak_pullup_en),
    .pc_load_value(pc_load_value), .pc_load(pc_load),
    .sysclk_sel(sysclk_sel), .wdt_enable_set(wdt_enable_set),
    .reset_cause(reset_cause));
  task automatic chk(input string nm, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic t_each;
    for (int i = 0; i < 8; i++) begin
      @(negedge core_clk) req = 8'h01 << i;
      @(negedge core_clk);
      chk("enter", {8'hff, 4'hf, i == 0 || i == 4, i == 0, 2'h0},
        {port_latch_force, core_halt, irq_timer_disable,
        reg_default_load, port_open_drain, external_reset_pin_n_oe,
        por_bits_load, 2'h0});
      chk("cause", 16'h1 << i, {8'h0, reset_cause});
      req = 8'h00;
      @(negedge core_clk);
      chk("exit", 16'h3, {port_latch_force, core_halt,
        external_reset_pin_n_oe, 4'h0, pc_load,
        wdt_enable_set});
      chk("fixed", 16'h2, pc_load_value | {sysclk_sel, ram_reset,
        weak_pullup_en, external_reset_pin_n_o});
      @(negedge core_clk) chk("pulse", 16'h0, {pc_load, wdt_enable_set});
    end
    $display("t_each done");
  endtask
  task automatic t_hold;
    @(negedge core_clk) req = 8'h20;
    @(negedge core_clk) req = 8'h28;
    @(negedge core_clk) req = 8'h08;
    @(negedge core_clk) chk("held", 16'h128, {core_halt, reset_cause});
    req = 8'h00;
    @(negedge core_clk) chk("free", 16'h1, {core_halt, pc_load});
    $display("t_hold done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    chk("rst", 16'h1, core_halt);
    rst = 0;
    repeat (3) @(negedge core_clk);
    t_each;
    t_hold;
    tally_and_finish;
  end
  initial begin
    #5000;
    n_errors++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
